// >>> design/tpf_channel.sv
// one output channel: compare level tracking, forcing and release level choice
`timescale 1ns/10ps
`default_nettype none
module tpf_channel (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire tpf_pkg::tpf_chan_in_t ci,
  output tpf_pkg::tpf_chan_st_t      st
);
  tpf_pkg::tpf_chan_st_t st_q, st_d;
  assign st = st_q;

  // the shadow level keeps toggling on every match even while forced
  always_comb begin
    st_d = st_q;
    if (ci.match)
      st_d.shadow = ~st_q.shadow;
    if (st_q.frcMode == tpf_pkg::FORCE_OFF)
      st_d.pin = st_d.shadow;
    if (ci.trough) begin
      case (ci.dutySel)
        tpf_pkg::DUTY_0: begin
          st_d.frcMode = tpf_pkg::FORCE_LOW;
          st_d.pin   = 1'b0;
        end
        tpf_pkg::DUTY_100: begin
          st_d.frcMode = tpf_pkg::FORCE_HIGH;
          st_d.pin   = 1'b1;
        end
        default: begin
          if (st_q.frcMode != tpf_pkg::FORCE_OFF) begin
            st_d.frcMode = tpf_pkg::FORCE_OFF;
            // end-of-period level on release
            case (ci.endLevel)
              tpf_pkg::END_LOW:  st_d.pin = 1'b0;
              tpf_pkg::END_HIGH: st_d.pin = 1'b1;
              default:           st_d.pin = ci.relSel ? st_d.shadow
                                     : (st_q.frcMode == tpf_pkg::FORCE_HIGH);
            endcase
            // compare tracking restarts from the release level, else the pin would
            // jump back to the masked level one cycle after the end-level choice
            st_d.shadow = st_d.pin;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      st_q <= '{frcMode: tpf_pkg::FORCE_OFF, shadow: 1'b0, pin: 1'b0};
    else
      st_q <= st_d;
  end

  // forced level stays put between troughs
  forced_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_q.frcMode == tpf_pkg::FORCE_HIGH && !ci.trough) |=> st_q.pin)
    else $error("forced high pin dropped");
  forced_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_q.frcMode == tpf_pkg::FORCE_LOW && !ci.trough) |=> !st_q.pin)
    else $error("forced low pin rose");
  force_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ci.trough && ci.dutySel == tpf_pkg::DUTY_100) |=> st_q.frcMode == tpf_pkg::FORCE_HIGH)
    else $error("100 percent not started at trough");
  no_early_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !ci.trough |=> $stable(st_q.frcMode))
    else $error("forcing changed off trough");
  shadow_runs_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ci.match && !ci.trough) |=> st_q.shadow != $past(st_q.shadow))
    else $error("compare tracking stopped");
  rel_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ci.trough && ci.dutySel == tpf_pkg::DUTY_NONE && st_q.frcMode != tpf_pkg::FORCE_OFF
     && ci.endLevel == tpf_pkg::END_LOW) |=> !st_q.pin)
    else $error("release level not low");
  rel_high_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ci.trough && ci.dutySel == tpf_pkg::DUTY_NONE && st_q.frcMode != tpf_pkg::FORCE_OFF
     && ci.endLevel == tpf_pkg::END_HIGH) |=> st_q.pin)
    else $error("release level not high");
  rel_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ci.trough && ci.dutySel == tpf_pkg::DUTY_NONE && st_q.frcMode == tpf_pkg::FORCE_HIGH
     && ci.endLevel == tpf_pkg::END_HOLD && !ci.relSel) |=> st_q.pin)
    else $error("hold release after 100 percent not high");
endmodule : tpf_channel
`default_nettype wire

// >>> design/tpf_pkg.sv
// package: register map, field layout and carrier types of the forced-duty pwm block
package tpf_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;   // forced-duty selects, release selects
  localparam logic [7:0] ADDR_LEVEL  = 8'h04;   // pin end-level selects
  localparam logic [7:0] ADDR_PERIOD = 8'h08;   // counter peak
  localparam logic [7:0] ADDR_CMPBUF = 8'h0C;   // compare buffers a/b
  localparam logic [7:0] ADDR_STAT   = 8'h10;   // sticky events, write one to clear
  localparam logic [7:0] ADDR_MASK   = 8'h14;   // interrupt enables
  localparam logic [7:0] ADDR_STATE  = 8'h18;   // live state

  // ctrl and level field positions
  localparam int CTRL_DUTY_A = 0;   // [1:0]
  localparam int CTRL_DUTY_B = 2;   // [3:2]
  localparam int CTRL_REL_A  = 4;
  localparam int CTRL_REL_B  = 5;
  localparam int CTRL_RUN    = 8;
  localparam int CTRL_CREST  = 9;   // start at crest
  localparam int LEVEL_A     = 0;   // [1:0]
  localparam int LEVEL_B     = 2;   // [3:2]
  // status bit positions
  localparam int ST_CMA   = 0;
  localparam int ST_CMB   = 1;
  localparam int ST_TROUGH = 2;
  localparam int ST_CREST = 3;

  localparam logic [15:0] PERIOD_RST = 16'h00FF;
  localparam logic [15:0] CMP_RST    = 16'h0080;

  // forced-duty encodings
  localparam logic [1:0] DUTY_NONE = 2'b00;
  localparam logic [1:0] DUTY_0    = 2'b10;
  localparam logic [1:0] DUTY_100  = 2'b11;
  // end-level encodings
  localparam logic [1:0] END_HOLD = 2'b00;
  localparam logic [1:0] END_LOW  = 2'b01;
  localparam logic [1:0] END_HIGH = 2'b10;

  typedef enum logic [1:0] {FORCE_OFF, FORCE_LOW, FORCE_HIGH} tpf_force_t;

  typedef struct packed {
    logic [1:0] dutySel;
    logic       relSel;
    logic [1:0] endLevel;
    logic       match;
    logic       trough;
  } tpf_chan_in_t;

  typedef struct packed {
    tpf_force_t frcMode;   // 'force' is a reserved word, so the field is named for what it holds
    logic       shadow;    // level compare matching would produce
    logic       pin;
  } tpf_chan_st_t;
endpackage : tpf_pkg

// >>> design/tpf_pwm_top.sv
// triangle-wave pwm timer with forced 0/100 percent duty per channel, ahb-lite slave
//
// Functional notes
// - forced duty only when output starts at trough; crest start blocks forcing
// - forcing works whether or not dead-time generation is enabled, all three modes
// - each channel has a two-bit forced-duty field that software changes
// - a forced-duty change takes effect only at the next trough
// - compare matching keeps running internally while forced; only the pin is masked
// - match interrupts and buffer transfers continue during forcing
// - release level chosen from pin end-level field and release-select bit
// - end-level hold: bit 0 gives forced level, bit 1 gives masked compare level
// - end-level 01b gives low after release
// - end-level 10b gives high after release
// - field 11b or 10b starts forcing at the trough
// - field 00b cancels forcing at the trough
// - release-select has no effect on entering forced duty; it only picks the end-level hold release level
`timescale 1ns/10ps
`default_nettype none
module tpf_pwm_top #(
  parameter int CNT_W = 16
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             pwmA,
  output logic             pwmB,
  output logic             irq
);
  typedef struct packed {
    logic             wrPend;
    logic [7:0]       addr;
    logic [31:0]      rdata;
    logic [1:0]       dutyA;
    logic [1:0]       dutyB;
    logic             relA;
    logic             relB;
    logic             run;
    logic             crestStart;
    logic [1:0]       lvlA;
    logic [1:0]       lvlB;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] bufA;
    logic [CNT_W-1:0] bufB;
    logic [CNT_W-1:0] cmpA;
    logic [CNT_W-1:0] cmpB;
    logic [CNT_W-1:0] cnt;
    logic             down;
    logic [3:0]       stat;
    logic [3:0]       mask;
    logic             pinA;
    logic             pinB;
  } tpf_top_st_t;

  tpf_top_st_t s_q, s_d;
  tpf_pkg::tpf_chan_in_t ciA, ciB;
  tpf_pkg::tpf_chan_st_t stA, stB;
  logic atTrough, atCrest, matchA, matchB, forceOk;
  logic [3:0] ev;

  function automatic logic [CNT_W-1:0] lo_word(input logic [31:0] w);
    lo_word = w[CNT_W-1:0];
  endfunction : lo_word

  // counter events
  assign atTrough = s_q.run && s_q.down && (s_q.cnt == '0);
  assign atCrest  = s_q.run && !s_q.down && (s_q.cnt == s_q.period);
  assign matchA   = s_q.run && (s_q.cnt == s_q.cmpA) && !atTrough;
  assign matchB   = s_q.run && (s_q.cnt == s_q.cmpB) && !atTrough;
  // crest start cannot reach forced duty, so fields are ignored then
  assign forceOk  = !s_q.crestStart;
  assign ev       = {atCrest, atTrough, matchB, matchA};

  // channel inputs: dead-time logic lies elsewhere and does not gate forcing
  always_comb begin
    ciA.dutySel  = forceOk ? s_q.dutyA : tpf_pkg::DUTY_NONE;
    ciA.relSel   = s_q.relA;
    ciA.endLevel = s_q.lvlA;
    ciA.match    = matchA;
    ciA.trough   = atTrough;
    ciB.dutySel  = forceOk ? s_q.dutyB : tpf_pkg::DUTY_NONE;
    ciB.relSel   = s_q.relB;
    ciB.endLevel = s_q.lvlB;
    ciB.match    = matchB;
    ciB.trough   = atTrough;
  end

  tpf_channel u_chA (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ci     (ciA),
    .st     (stA)
  );
  tpf_channel u_chB (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ci     (ciB),
    .st     (stB)
  );

  // bus, counter, buffer transfer and status in one next-state process
  always_comb begin
    s_d = s_q;
    s_d.pinA = stA.pin;
    s_d.pinB = stB.pin;
    // triangle counter
    if (s_q.run) begin
      if (atCrest)
        s_d.down = 1'b1;
      else if (atTrough)
        s_d.down = 1'b0;
      if (s_q.down && !atTrough)
        s_d.cnt = s_q.cnt - 1'b1;
      else if (!atCrest)
        s_d.cnt = s_q.cnt + 1'b1;
      else
        s_d.cnt = s_q.cnt - 1'b1;
      if (atTrough)
        s_d.cnt = s_q.cnt + 1'b1;
    end
    // buffers move into compare at the trough even while forced
    if (atTrough) begin
      s_d.cmpA = s_q.bufA;
      s_d.cmpB = s_q.bufB;
    end
    // bus write data phase
    if (s_q.wrPend) begin
      case (s_q.addr)
        tpf_pkg::ADDR_CTRL: begin
          s_d.dutyA      = hwdata[tpf_pkg::CTRL_DUTY_A +: 2];
          s_d.dutyB      = hwdata[tpf_pkg::CTRL_DUTY_B +: 2];
          s_d.relA       = hwdata[tpf_pkg::CTRL_REL_A];
          s_d.relB       = hwdata[tpf_pkg::CTRL_REL_B];
          s_d.run        = hwdata[tpf_pkg::CTRL_RUN];
          s_d.crestStart = hwdata[tpf_pkg::CTRL_CREST];
          if (hwdata[tpf_pkg::CTRL_RUN] && !s_q.run) begin
            s_d.cnt  = hwdata[tpf_pkg::CTRL_CREST] ? s_q.period : '0;
            s_d.down = hwdata[tpf_pkg::CTRL_CREST];
          end
        end
        tpf_pkg::ADDR_LEVEL: begin
          s_d.lvlA = hwdata[tpf_pkg::LEVEL_A +: 2];
          s_d.lvlB = hwdata[tpf_pkg::LEVEL_B +: 2];
        end
        tpf_pkg::ADDR_PERIOD: s_d.period = lo_word(hwdata);
        tpf_pkg::ADDR_CMPBUF: begin
          s_d.bufA = hwdata[CNT_W-1:0];
          s_d.bufB = hwdata[16 +: CNT_W];
        end
        tpf_pkg::ADDR_STAT: s_d.stat = s_q.stat & ~hwdata[3:0];
        tpf_pkg::ADDR_MASK: s_d.mask = hwdata[3:0];
        default: ;
      endcase
    end
    // set wins over a simultaneous write-one clear
    s_d.stat = s_d.stat | ev;
    // address phase
    s_d.wrPend = 1'b0;
    s_d.rdata  = '0;
    if (hsel && hready && htrans[1]) begin
      s_d.wrPend = hwrite;
      s_d.addr   = haddr;
      if (!hwrite) begin
        case (haddr)
          tpf_pkg::ADDR_CTRL: s_d.rdata = {22'h0, s_q.crestStart, s_q.run, 2'b00,
                                          s_q.relB, s_q.relA, s_q.dutyB, s_q.dutyA};
          tpf_pkg::ADDR_LEVEL:  s_d.rdata = {28'h0, s_q.lvlB, s_q.lvlA};
          tpf_pkg::ADDR_PERIOD: s_d.rdata = {16'h0, s_q.period};
          tpf_pkg::ADDR_CMPBUF: s_d.rdata = {s_q.bufB, s_q.bufA};
          tpf_pkg::ADDR_STAT:   s_d.rdata = {28'h0, s_q.stat};
          tpf_pkg::ADDR_MASK:   s_d.rdata = {28'h0, s_q.mask};
          tpf_pkg::ADDR_STATE:  s_d.rdata = {s_q.cnt, 7'h00, s_q.down, 2'b00,
                                             stB.frcMode, stA.frcMode, stB.pin, stA.pin};
          default:              s_d.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q        <= '0;
      s_q.period <= tpf_pkg::PERIOD_RST;
      s_q.bufA   <= tpf_pkg::CMP_RST;
      s_q.bufB   <= tpf_pkg::CMP_RST;
      s_q.cmpA   <= tpf_pkg::CMP_RST;
      s_q.cmpB   <= tpf_pkg::CMP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; slave always ready, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign pwmA      = s_q.pinA;
  assign pwmB      = s_q.pinB;
  assign irq       = |(s_q.stat & s_q.mask);

  crest_block_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_q.crestStart |-> ciA.dutySel == tpf_pkg::DUTY_NONE)
    else $error("forcing allowed with crest start");
  match_irq_a: assert property (@(posedge mclk) disable iff (!arst_n)
    matchA |=> s_q.stat[tpf_pkg::ST_CMA])
    else $error("match event lost");
  buf_xfer_a: assert property (@(posedge mclk) disable iff (!arst_n)
    atTrough |=> s_q.cmpA == $past(s_q.bufA))
    else $error("buffer transfer missing");
endmodule : tpf_pwm_top
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the forced-duty pwm block
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [1:0] duty;
    logic [1:0] endLvl;
    logic       rel;
    logic       frc;
    logic       aft;
  } tpf_row_t;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        pwmA;
  logic        pwmB;
  logic        irq;
  logic        clr = 1'b1;
  logic [15:0] hiA;
  logic [15:0] loA;
  logic [15:0] hiB;
  logic [15:0] loB;
  logic [31:0] rd;
  int          errorCnt = 0;
  int          samplesChecked = 0;
  logic [7:0]  rstAddr [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h1C};
  logic [31:0] rstVal [5] = '{32'h0, 32'h0000_00FF, 32'h0080_0080, 32'h0, 32'h0};
  // duty, end level, release select, pin while forced, pin after release
  tpf_row_t    rows [6] = '{
    '{tpf_pkg::DUTY_0,   tpf_pkg::END_LOW,  1'b1, 1'b0, 1'b0},
    '{tpf_pkg::DUTY_100, tpf_pkg::END_LOW,  1'b0, 1'b1, 1'b0},
    '{tpf_pkg::DUTY_0,   tpf_pkg::END_HIGH, 1'b0, 1'b0, 1'b1},
    '{tpf_pkg::DUTY_100, tpf_pkg::END_HIGH, 1'b1, 1'b1, 1'b1},
    '{tpf_pkg::DUTY_0,   tpf_pkg::END_HOLD, 1'b0, 1'b0, 1'b0},
    '{tpf_pkg::DUTY_100, tpf_pkg::END_HOLD, 1'b0, 1'b1, 1'b1}};

  always #4 mclk = ~mclk;

  tpf_pwm_top #(.CNT_W(16)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwmA(pwmA),
    .pwmB(pwmB), .irq(irq));

  tpf_gate_model gate_u (
    .mclk(mclk), .clr(clr), .pwmA(pwmA), .pwmB(pwmB),
    .hiA_q(hiA), .loA_q(loA), .hiB_q(hiB), .loB_q(loB));

  task automatic results();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH %0t %s got %h", $time, what, got);
    end
  endtask : chk

  // hready is looked at mid-cycle, so the value seen is the one the next edge samples
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin @(negedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(negedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    @(posedge mclk);
    if (n >= 50) begin
      errorCnt++;
      $display("MISMATCH %0t bus never ready", $time);
      results();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdReg(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rdReg

  // clears the sticky bits, waits for the trough interrupt, lands a few counts past it
  task automatic waitTrough();
    int n;
    wr(tpf_pkg::ADDR_STAT, 32'h0000_000F);
    repeat (2) @(posedge mclk);
    n = 0;
    do begin @(negedge mclk); n++; end while (irq !== 1'b1 && n < 200);
    if (n >= 200) begin
      errorCnt++;
      $display("MISMATCH %0t trough never came", $time);
      results();
    end
    repeat (4) @(posedge mclk);
  endtask : waitTrough

  function automatic logic [31:0] ctlWord(input logic [1:0] d, input logic r);
    return {23'h0, 1'b1, 2'b00, r, r, d, d};
  endfunction : ctlWord

  // reset, the forcing table, then crest start, interrupt and a second reset
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    chk({27'h0, pwmA, pwmB, irq, hreadyout, hresp}, 32'h0000_0002, "reset outputs");
    @(posedge mclk);
    foreach (rstAddr[i]) begin
      rdReg(rstAddr[i]);
      chk(rd, rstVal[i], "reset value");
    end
    wr(8'h1C, 32'hFFFF_FFFF);
    rdReg(8'h1C);
    chk(rd, 32'h0000_0000, "unmapped read");
    // short period keeps each row to a few dozen cycles
    wr(tpf_pkg::ADDR_PERIOD, 32'h0000_0010);
    wr(tpf_pkg::ADDR_CMPBUF, 32'h0008_0008);
    wr(tpf_pkg::ADDR_MASK, 32'h0000_0004);
    wr(tpf_pkg::ADDR_CTRL, 32'h0000_0100);
    waitTrough();
    foreach (rows[i]) begin
      wr(tpf_pkg::ADDR_LEVEL, {28'h0, rows[i].endLvl, rows[i].endLvl});
      wr(tpf_pkg::ADDR_CTRL, ctlWord(rows[i].duty, rows[i].rel));
      rdReg(tpf_pkg::ADDR_STATE);
      chk({28'h0, rd[5:2]}, 32'h0, "force took effect early");
      waitTrough();
      clr <= 1'b0;
      @(negedge mclk);
      chk({30'h0, pwmB, pwmA}, {30'h0, rows[i].frc, rows[i].frc}, "forced pin");
      waitTrough();
      chk({28'h0, hiA == 16'h0, loA == 16'h0, hiB == 16'h0, loB == 16'h0},
          {28'h0, ~rows[i].frc, rows[i].frc, ~rows[i].frc, rows[i].frc}, "steady");
      rdReg(tpf_pkg::ADDR_STAT);
      chk({29'h0, rd[2:0]}, 32'h0000_0007, "events while forced");
      wr(tpf_pkg::ADDR_CTRL, ctlWord(tpf_pkg::DUTY_NONE, rows[i].rel));
      clr <= 1'b1;
      waitTrough();
      @(negedge mclk);
      chk({30'h0, pwmB, pwmA}, {30'h0, rows[i].aft, rows[i].aft}, "release level");
      $display("row %0d done", i);
    end
    wr(tpf_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(tpf_pkg::ADDR_CTRL, 32'h0000_030F);
    waitTrough();
    waitTrough();
    rdReg(tpf_pkg::ADDR_STATE);
    chk({28'h0, rd[5:2]}, 32'h0, "crest start forced");
    $display("crest start done");
    // counter stopped so the sticky trough bit stays put
    wr(tpf_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(tpf_pkg::ADDR_MASK, 32'h0000_0000);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(tpf_pkg::ADDR_MASK, 32'h0000_0004);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(tpf_pkg::ADDR_STAT, 32'h0000_0004);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    $display("interrupt done");
    wr(tpf_pkg::ADDR_CTRL, 32'h0000_010F);
    waitTrough();
    arst_n <= 1'b0;
    @(negedge mclk);
    chk({29'h0, pwmA, pwmB, irq}, 32'h0, "mid-run reset");
    @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rdReg(tpf_pkg::ADDR_PERIOD);
    chk(rd, 32'h0000_00FF, "period after reset");
    $display("second reset done");
    results();
  end
endmodule : tb
`default_nettype wire

// >>> dv/tpf_gate_model.sv
// gate-driver stand-in: tallies the cycles each pwm pin spends high and low
`timescale 1ns/10ps
`default_nettype none
module tpf_gate_model (
  input  wire logic        mclk,
  input  wire logic        clr,
  input  wire logic        pwmA,
  input  wire logic        pwmB,
  output logic      [15:0] hiA_q,
  output logic      [15:0] loA_q,
  output logic      [15:0] hiB_q,
  output logic      [15:0] loB_q
);
  // a forced pin shows one level only, so one tally staying at zero is the evidence
  always_ff @(posedge mclk) begin
    if (clr) begin
      hiA_q <= 16'h0000;
      loA_q <= 16'h0000;
      hiB_q <= 16'h0000;
      loB_q <= 16'h0000;
    end else begin
      hiA_q <= hiA_q + {15'h0000, pwmA};
      loA_q <= loA_q + {15'h0000, ~pwmA};
      hiB_q <= hiB_q + {15'h0000, pwmB};
      loB_q <= loB_q + {15'h0000, ~pwmB};
    end
  end
endmodule : tpf_gate_model
`default_nettype wire
